// ===== verilog/osd_pkg.sv
// Package for the oscillator select, switch and doze control block.
package osd_pkg;

   // ----------------------------------------------------------------
   // Register map (word offsets on the Avalon-MM bus)
   // ----------------------------------------------------------------
   localparam logic [3:0] OSD_ADDR_OSC_CONTROL = 4'h0;
   localparam logic [3:0] OSD_ADDR_CLOCK_DIVIDER = 4'h4;
   localparam logic [3:0] OSD_ADDR_PLL_FEEDBACK = 4'h8;
   localparam logic [3:0] OSD_ADDR_STATUS = 4'hC;

   // ----------------------------------------------------------------
   // Unlock keys
   // ----------------------------------------------------------------
   localparam logic [7:0] OSD_KEY_HIGH_1 = 8'h78;
   localparam logic [7:0] OSD_KEY_HIGH_2 = 8'h9A;
   localparam logic [7:0] OSD_KEY_LOW_1 = 8'h46;
   localparam logic [7:0] OSD_KEY_LOW_2 = 8'h57;

   // ----------------------------------------------------------------
   // Source codes and primary sub-modes
   // ----------------------------------------------------------------
   localparam logic [2:0] OSD_SRC_FAST_RC = 3'h0;
   localparam logic [2:0] OSD_SRC_FAST_RC_WITH_PLL = 3'h1;
   localparam logic [2:0] OSD_SRC_PRIMARY = 3'h2;
   localparam logic [2:0] OSD_SRC_PRIMARY_PLL = 3'h3;
   localparam logic [2:0] OSD_SRC_RESERVED = 3'h4;
   localparam logic [2:0] OSD_SRC_LOW_POWER_RC = 3'h5;
   localparam logic [2:0] OSD_SRC_BACKUP_FAST_RC = 3'h6;
   localparam logic [2:0] OSD_SRC_FAST_RC_DIV_N = 3'h7;
   localparam logic [1:0] OSD_PRI_EXT_CLOCK_IN = 2'h0;
   localparam logic [1:0] OSD_PRI_MEDIUM_CRYSTAL = 2'h1;
   localparam logic [1:0] OSD_PRI_HIGH_GAIN_CRYSTAL = 2'h2;
   localparam logic [1:0] OSD_PRI_OFF = 2'h3;

   // ----------------------------------------------------------------
   // Bit positions and reset values
   // ----------------------------------------------------------------
   localparam int OSD_BIT_SWITCH_REQUEST = 0;
   localparam int OSD_BIT_CLOCK_FAIL = 3;
   localparam int OSD_BIT_PLL_LOCK = 5;
   localparam int OSD_BIT_CONFIG_LOCK = 7;
   localparam logic [2:0] OSD_DOZE_RESET = 3'h3;
   localparam logic [2:0] OSD_DOZE_ONE = 3'h0;
   localparam logic [2:0] OSD_POSTSCALE_RESET = 3'h0;
   localparam logic [3:0] OSD_PLL_PRESCALE_RESET = 4'h1;
   localparam logic [7:0] OSD_PLL_MULT_RESET = 8'h96;

   // ----------------------------------------------------------------
   // Clock switch timing
   // ----------------------------------------------------------------
   localparam int OSD_CLK_MHZ = 125;
   localparam int OSD_SWITCH_NS = 64;
   localparam int OSD_SWITCH_CYCLES = (OSD_SWITCH_NS * OSD_CLK_MHZ + 999) / 1000;

   typedef enum logic [2:0] {
      OSD_SW_IDLE = 3'b001,
      OSD_SW_WAIT = 3'b010,
      OSD_SW_DONE = 3'b100
   } osd_sw_state_t;

   // Configuration straps caught at power-on.
   typedef struct packed {
      logic [2:0] power_on_source_select;
      logic [1:0] primary_osc_mode;
      logic switch_mode_fuse_bit0;
   } osd_config_t;

   // Clock tree controls driven out of the block.
   typedef struct packed {
      logic [2:0] current_source;
      logic [1:0] primary_mode;
      logic [2:0] fast_rc_postscale;
      logic [3:0] pll_prescale;
      logic [7:0] pll_feedback_mult;
      logic [2:0] reduction_ratio;
      logic reduction_active;
   } osd_clock_ctrl_t;

endpackage

// ===== verilog/osd_ctrl.sv
// Oscillator select, clock switch, unlock, doze and PLL divider control.
`timescale 1ns/10ps
// What this block does
// - Low-power RC on at power-on; kept by monitor, watchdog or selection, else off after timer.
// - Low-power RC is off in Sleep.
// - Power-on source comes from the 3-bit configuration code.
// - Primary sub-mode comes from the 2-bit configuration field.
// - Erased configuration (111) starts in fast RC divided by N.
// - Upper byte unlocks with 0x78 then 0x9A; next write may change bits 10:8.
// - Lower byte unlocks with 0x46 then 0x57; next write may change bits 7:0.
// - Upper and lower bytes have separate lock state machines.
// - Read-only current-source field; reserved 100 runs as fast RC.
// - Switch-request starts a switch and clears when the switch completes.
// - Lock bit with fuse bit 0 set blocks clock and PLL changes.
// - PLL lock bit reads 1 when a PLL source is current and locked or start-up timer elapsed, else 0.
// - Failure sets clock-fail; software 1 acts as failure; only software clears.
// - Reduction ratio writes are ignored while reduction is enabled.
// - Setting reduction enable is ignored while ratio is 000.
// - Fast RC postscaler 000 divide by 1 at reset, up to 256.
// - PLL prescaler divides by 1 to 8, resets to 1.
// - Prescaler updates are accepted while the PLL runs.
module osd_ctrl
   import osd_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire osd_config_t config_bits,
   input wire logic fail_safe_monitor_en,
   input wire logic watchdog_timer_en,
   input wire logic power_up_timer_done,
   input wire logic sleep_mode,
   input wire logic fail_detect,
   input wire logic pll_locked,
   input wire logic pll_timer_done,
   input wire logic irq_any,
   output logic low_power_rc_osc_en,
   output logic osc_fail_trap,
   output logic clock_tree_switch,
   output osd_clock_ctrl_t clock_ctrl
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   localparam int NSYNC = 7;
   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   assign async_in = {fail_safe_monitor_en, watchdog_timer_en, power_up_timer_done, sleep_mode,
                      fail_detect, pll_locked, pll_timer_done};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
            end else begin
               sync1_q[gi] <= async_in[gi];
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate
   wire monitor_s = sync2_q[6];
   wire watchdog_s = sync2_q[5];
   wire power_up_timer_done_s = sync2_q[4];
   wire sleep_s = sync2_q[3];
   wire fail_s = sync2_q[2];
   wire locked_s = sync2_q[1];
   wire pll_timer_s = sync2_q[0];

   // ----------------------------------------------------------------
   // Power-on capture of configuration straps
   // ----------------------------------------------------------------
   logic cfg_loaded_q;
   osd_config_t cfg_q;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_loaded_q <= 1'b0;
         cfg_q <= '0;
      end else if (!cfg_loaded_q) begin
         cfg_loaded_q <= 1'b1;
         cfg_q <= config_bits;
      end
   end

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Waitrequest holds one cycle while the straps load, so no access
   // races the power-on source capture.
   logic ack_q;
   wire access = (avs_read || avs_write) && cfg_loaded_q;
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   wire take = access && !ack_q;
   wire wr = take && avs_write;
   wire sel_osc = avs_address == OSD_ADDR_OSC_CONTROL;
   wire sel_div = avs_address == OSD_ADDR_CLOCK_DIVIDER;
   wire sel_fbd = avs_address == OSD_ADDR_PLL_FEEDBACK;
   wire wr_hi = wr && sel_osc && avs_byteenable[1];
   wire wr_lo = wr && sel_osc && avs_byteenable[0];
   wire [7:0] hi_byte = avs_writedata[15:8];
   wire [7:0] lo_byte = avs_writedata[7:0];

   // ----------------------------------------------------------------
   // Unlock state machines, one per byte
   // ----------------------------------------------------------------
   // A write of the first key arms, the second opens, and any other
   // write to that byte closes again. Only the write after the open
   // state changes the bits; that write closes the byte itself.
   logic [1:0] hi_lock_q;
   logic [1:0] lo_lock_q;
   wire hi_open = hi_lock_q == 2'h2;
   wire lo_open = lo_lock_q == 2'h2;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         hi_lock_q <= 2'h0;
         lo_lock_q <= 2'h0;
      end else begin
         if (wr_hi) begin
            hi_lock_q <= (hi_lock_q == 2'h1 && hi_byte == OSD_KEY_HIGH_2) ? 2'h2 :
                         (hi_lock_q != 2'h2 && hi_byte == OSD_KEY_HIGH_1) ? 2'h1 : 2'h0;
         end
         if (wr_lo) begin
            lo_lock_q <= (lo_lock_q == 2'h1 && lo_byte == OSD_KEY_LOW_2) ? 2'h2 :
                         (lo_lock_q != 2'h2 && lo_byte == OSD_KEY_LOW_1) ? 2'h1 : 2'h0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Oscillator control register
   // ----------------------------------------------------------------
   logic [2:0] cur_src_q;
   logic [2:0] new_src_q;
   logic switch_req_q;
   logic cfg_lock_q;
   logic fail_q;
   logic fail_sw_q;
   osd_sw_state_t sw_state_q;
   logic [3:0] sw_cnt_q;

   wire locked_cfg = cfg_lock_q && cfg_q.switch_mode_fuse_bit0;
   wire hi_commit = wr_hi && hi_open && !locked_cfg;
   wire lo_commit = wr_lo && lo_open;
   wire switch_start = lo_commit && lo_byte[OSD_BIT_SWITCH_REQUEST] && !locked_cfg;
   wire switch_end = sw_state_q == OSD_SW_DONE;
   wire fail_set_sw = lo_commit && lo_byte[OSD_BIT_CLOCK_FAIL];
   wire fail_clr_sw = lo_commit && !lo_byte[OSD_BIT_CLOCK_FAIL];

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         new_src_q <= OSD_SRC_FAST_RC;
         cur_src_q <= OSD_SRC_FAST_RC;
      end else if (!cfg_loaded_q) begin
         new_src_q <= config_bits.power_on_source_select;
         cur_src_q <= config_bits.power_on_source_select;
      end else begin
         if (hi_commit) begin
            new_src_q <= hi_byte[2:0];
         end
         if (switch_end) begin
            cur_src_q <= new_src_q;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         switch_req_q <= 1'b0;
         cfg_lock_q <= 1'b0;
         fail_q <= 1'b0;
         fail_sw_q <= 1'b0;
      end else begin
         if (switch_start) begin
            switch_req_q <= 1'b1;
         end else if (switch_end) begin
            switch_req_q <= 1'b0;
         end
         if (lo_commit && !locked_cfg) begin
            cfg_lock_q <= lo_byte[OSD_BIT_CONFIG_LOCK];
         end
         // A detected failure wins over a software clear in the same cycle.
         if (fail_s || fail_set_sw) begin
            fail_q <= 1'b1;
         end else if (fail_clr_sw) begin
            fail_q <= 1'b0;
         end
         fail_sw_q <= fail_set_sw;
      end
   end

   // A fixed settle count stands in for the clock multiplexer's own
   // glitch-free handover, which is outside this block.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_state_q <= OSD_SW_IDLE;
         sw_cnt_q <= '0;
      end else begin
         case (sw_state_q)
            OSD_SW_IDLE: begin
               sw_cnt_q <= '0;
               if (switch_start) begin
                  sw_state_q <= OSD_SW_WAIT;
               end
            end
            OSD_SW_WAIT: begin
               sw_cnt_q <= sw_cnt_q + 4'h1;
               if (sw_cnt_q == 4'(OSD_SWITCH_CYCLES - 1)) begin
                  sw_state_q <= OSD_SW_DONE;
               end
            end
            OSD_SW_DONE: begin
               sw_state_q <= OSD_SW_IDLE;
            end
            default: begin
               sw_state_q <= OSD_SW_IDLE;
            end
         endcase
      end
   end

   wire [2:0] cur_src_eff = (cur_src_q == OSD_SRC_RESERVED) ? OSD_SRC_FAST_RC : cur_src_q;
   wire pll_lock_bit = locked_s || pll_timer_s;
   wire pll_in_use = cur_src_eff == OSD_SRC_FAST_RC_WITH_PLL || cur_src_eff == OSD_SRC_PRIMARY_PLL;
   wire lock_status = pll_in_use && pll_lock_bit;

   // ----------------------------------------------------------------
   // Clock divider and feedback registers
   // ----------------------------------------------------------------
   logic recover_q;
   logic [2:0] doze_q;
   logic doze_en_q;
   logic [2:0] postscale_q;
   logic [3:0] prescale_q;
   logic [7:0] mult_q;
   logic irq_q;
   wire div_hi = wr && sel_div && avs_byteenable[1] && !locked_cfg;
   wire div_lo = wr && sel_div && avs_byteenable[0] && !locked_cfg;
   wire fbd_lo = wr && sel_fbd && avs_byteenable[0] && !locked_cfg;
   wire recover_hit = recover_q && irq_any;
   wire [2:0] doze_next = (div_hi && !doze_en_q) ? avs_writedata[14:12] : doze_q;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         recover_q <= 1'b0;
         doze_q <= OSD_DOZE_RESET;
         doze_en_q <= 1'b0;
         postscale_q <= OSD_POSTSCALE_RESET;
      end else begin
         if (div_hi) begin
            recover_q <= avs_writedata[15];
            doze_q <= doze_next;
            postscale_q <= avs_writedata[10:8];
         end
         // An interrupt wins over a software set in the same cycle.
         if (recover_hit) begin
            doze_en_q <= 1'b0;
         end else if (div_hi) begin
            doze_en_q <= avs_writedata[11] && (doze_next != OSD_DOZE_ONE);
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prescale_q <= OSD_PLL_PRESCALE_RESET;
         mult_q <= OSD_PLL_MULT_RESET;
         irq_q <= 1'b0;
      end else begin
         if (div_lo) begin
            prescale_q <= avs_writedata[3:0];
         end
         if (fbd_lo) begin
            mult_q <= avs_writedata[7:0];
         end
         irq_q <= irq_any;
      end
   end

   // ----------------------------------------------------------------
   // Read data and bus answer
   // ----------------------------------------------------------------
   wire [15:0] osc_word = {1'b0, cur_src_eff, 1'b0, new_src_q, cfg_lock_q, 1'b0, lock_status, 1'b0,
                           fail_q, 2'b00, switch_req_q};
   wire [15:0] div_word = {recover_q, doze_q, doze_en_q, postscale_q, 4'h0, prescale_q};
   wire [15:0] fbd_word = {8'h00, mult_q};
   wire [15:0] sta_word = {12'h000, irq_q, low_power_rc_osc_en, pll_lock_bit, sw_state_q == OSD_SW_WAIT};
   wire [15:0] rd_word = sel_osc ? osc_word :
                         sel_div ? div_word :
                         sel_fbd ? fbd_word :
                         (avs_address == OSD_ADDR_STATUS) ? sta_word : 16'h0000;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
         avs_readdata <= '0;
      end else begin
         ack_q <= take;
         if (take && avs_read) begin
            avs_readdata <= {16'h0000, rd_word};
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   logic low_power_rc_osc_q;
   logic trap_q;
   logic switch_q;
   osd_clock_ctrl_t ctrl_q;
   wire low_power_rc_osc_keep = monitor_s || watchdog_s || cur_src_eff == OSD_SRC_LOW_POWER_RC;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         low_power_rc_osc_q <= 1'b1;
         trap_q <= 1'b0;
         switch_q <= 1'b0;
         ctrl_q <= '0;
      end else begin
         low_power_rc_osc_q <= !sleep_s && (low_power_rc_osc_keep || !power_up_timer_done_s);
         trap_q <= fail_s || fail_sw_q;
         switch_q <= switch_end;
         ctrl_q.current_source <= cur_src_eff;
         ctrl_q.primary_mode <= (cur_src_eff == OSD_SRC_PRIMARY || cur_src_eff == OSD_SRC_PRIMARY_PLL) ?
                                cfg_q.primary_osc_mode : OSD_PRI_OFF;
         ctrl_q.fast_rc_postscale <= postscale_q;
         ctrl_q.pll_prescale <= prescale_q;
         ctrl_q.pll_feedback_mult <= mult_q;
         ctrl_q.reduction_ratio <= doze_en_q ? doze_q : OSD_DOZE_ONE;
         ctrl_q.reduction_active <= doze_en_q;
      end
   end
   assign low_power_rc_osc_en = low_power_rc_osc_q;
   assign osc_fail_trap = trap_q;
   assign clock_tree_switch = switch_q;
   assign clock_ctrl = ctrl_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_upper_unlock_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
      ($past(cfg_loaded_q) && $changed(new_src_q)) |-> $past(hi_open))
      else $error("New-source changed without upper unlock.");
   a_lower_unlock_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(switch_req_q) |-> $past(lo_open))
      else $error("Switch request set without lower unlock.");
   a_switch_completes: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(switch_req_q) |-> ##[1:20] !switch_req_q)
      else $error("Switch request did not clear.");
   a_reserved_as_fast: assert property (@(posedge core_clk) disable iff (!rst_b)
      (cur_src_q == OSD_SRC_RESERVED) |=> clock_ctrl.current_source == OSD_SRC_FAST_RC)
      else $error("Current source shows reserved code.");
   a_fail_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
      (fail_q && !fail_clr_sw) |=> fail_q)
      else $error("Clock-fail cleared without software.");
   a_doze_ratio_held: assert property (@(posedge core_clk) disable iff (!rst_b)
      $past(doze_en_q) |-> $stable(doze_q))
      else $error("Reduction ratio changed while enabled.");
   a_doze_not_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
      doze_en_q |-> doze_q != OSD_DOZE_ONE)
      else $error("Reduction enabled with ratio zero.");
   a_recover_clears: assert property (@(posedge core_clk) disable iff (!rst_b)
      recover_hit |=> !doze_en_q ##1 ctrl_q.reduction_ratio == OSD_DOZE_ONE)
      else $error("Interrupt did not end reduction.");
   a_sleep_low_power_rc_osc_off: assert property (@(posedge core_clk) disable iff (!rst_b)
      sleep_s |=> !low_power_rc_osc_en)
      else $error("Low-power RC running in Sleep.");
   a_lock_blocks: assert property (@(posedge core_clk) disable iff (!rst_b)
      locked_cfg |=> $stable(prescale_q) && $stable(mult_q))
      else $error("PLL settings changed while locked.");

endmodule

// ===== tb/tb_osd_ctrl.sv
// Self-checking testbench for the oscillator select, switch and doze control block.
`timescale 1ns/10ps
module tb_osd_ctrl;
   import osd_pkg::*;
   logic core_clk, rst_b, avs_read, avs_write, avs_waitrequest, irq_any;
   logic [1:0] seen;
   logic [3:0] avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic fail_safe_monitor_en, watchdog_timer_en, power_up_timer_done, sleep_mode, fail_detect;
   logic pll_locked, pll_timer_done, low_power_rc_osc_en, osc_fail_trap, clock_tree_switch;
   osd_config_t config_bits;
   osd_clock_ctrl_t clock_ctrl;
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;

   osd_ctrl u_dut (.core_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .config_bits, .fail_safe_monitor_en,
      .watchdog_timer_en, .power_up_timer_done, .sleep_mode, .fail_detect, .pll_locked,
      .pll_timer_done, .irq_any, .low_power_rc_osc_en, .osc_fail_trap, .clock_tree_switch, .clock_ctrl);

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // The whole run needs a few hundred cycles, so this ceiling only trips on a hang.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // Bus and comparison tasks
   // ----------------------------------------------------------------
   task automatic wrap_up();
      if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // The request stands until a rising edge samples waitrequest low; read data is taken at that edge.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d, input logic [3:0] be);
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= ~wr;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 16'h0000, 4'hF);
      chk(nm, e, rd);
   endtask
   task automatic hi(input logic [7:0] v);
      bus(1'b1, OSD_ADDR_OSC_CONTROL, {v, 8'h00}, 4'h2);
   endtask
   task automatic lo(input logic [7:0] v);
      bus(1'b1, OSD_ADDR_OSC_CONTROL, {8'h00, v}, 4'h1);
   endtask
   task automatic unl_hi(input logic [7:0] v);
      hi(OSD_KEY_HIGH_1);
      hi(OSD_KEY_HIGH_2);
      hi(v);
   endtask
   task automatic unl_lo(input logic [7:0] v);
      lo(OSD_KEY_LOW_1);
      lo(OSD_KEY_LOW_2);
      lo(v);
   endtask
   task automatic wdiv(input logic [3:0] a, input logic [15:0] d);
      bus(1'b1, a, d, 4'h3);
   endtask
   task automatic settle();
      repeat (5) @(posedge core_clk);
   endtask
   task automatic watch(input int n);
      seen = 2'b00;
      repeat (n) begin
         @(posedge core_clk);
         if (clock_tree_switch === 1'b1) seen[0] = 1'b1;
         if (osc_fail_trap === 1'b1) seen[1] = 1'b1;
      end
   endtask
   task automatic do_reset(input osd_config_t c);
      rst_b <= 1'b0;
      config_bits <= c;
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge core_clk);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_values();
      rchk("osc_control", OSD_ADDR_OSC_CONTROL, 32'h0000_7700);
      rchk("clock_divider", OSD_ADDR_CLOCK_DIVIDER, 32'h0000_3001);
      rchk("pll_feedback", OSD_ADDR_PLL_FEEDBACK, 32'h0000_0096);
      rchk("unmapped", 4'h2, 32'h0000_0000);
      chk("low_power_rc_osc_en", 32'h1, {31'h0, low_power_rc_osc_en});
   endtask
   task automatic t_unlock_switch();
      hi(8'h03);
      rchk("new_src_locked", OSD_ADDR_OSC_CONTROL, 32'h0000_7700);
      unl_hi(8'h03);
      rchk("new_src_open", OSD_ADDR_OSC_CONTROL, 32'h0000_7300);
      lo(8'h01);
      rchk("low_locked", OSD_ADDR_OSC_CONTROL, 32'h0000_7300);
      unl_lo(8'h01);
      watch(40);
      chk("switch_pulse", 32'h1, {30'h0, seen});
      rchk("switched", OSD_ADDR_OSC_CONTROL, 32'h0000_3300);
      chk("current_out", 32'h3, {29'h0, clock_ctrl.current_source});
      chk("primary_mode", 32'h1, {30'h0, clock_ctrl.primary_mode});
   endtask
   task automatic t_pll();
      pll_locked <= 1'b1;
      settle();
      rchk("pll_lock_on", OSD_ADDR_OSC_CONTROL, 32'h0000_3320);
      rchk("status_lock", OSD_ADDR_STATUS, 32'h0000_0006);
      pll_locked <= 1'b0;
      settle();
      rchk("pll_lock_off", OSD_ADDR_OSC_CONTROL, 32'h0000_3300);
      pll_timer_done <= 1'b1;
      settle();
      rchk("pll_timer", OSD_ADDR_OSC_CONTROL, 32'h0000_3320);
      pll_timer_done <= 1'b0;
      wdiv(OSD_ADDR_CLOCK_DIVIDER, 16'h3608);
      rchk("prescale", OSD_ADDR_CLOCK_DIVIDER, 32'h0000_3608);
      chk("prescale_out", 32'h8, {28'h0, clock_ctrl.pll_prescale});
      chk("postscale_out", 32'h6, {29'h0, clock_ctrl.fast_rc_postscale});
      wdiv(OSD_ADDR_PLL_FEEDBACK, 16'h00C8);
      rchk("feedback", OSD_ADDR_PLL_FEEDBACK, 32'h0000_00C8);
      chk("mult_out", 32'hC8, {24'h0, clock_ctrl.pll_feedback_mult});
   endtask
   task automatic t_fail();
      unl_lo(8'h08);
      rchk("cf_soft_set", OSD_ADDR_OSC_CONTROL, 32'h0000_3308);
      unl_lo(8'h00);
      rchk("cf_soft_clr", OSD_ADDR_OSC_CONTROL, 32'h0000_3300);
      fail_detect <= 1'b1;
      watch(10);
      chk("fail_trap", 32'h2, {30'h0, seen});
      fail_detect <= 1'b0;
      settle();
      rchk("cf_held", OSD_ADDR_OSC_CONTROL, 32'h0000_3308);
   endtask
   task automatic t_doze();
      wdiv(OSD_ADDR_CLOCK_DIVIDER, 16'h3801);
      chk("doze_on", 32'h7, {28'h0, clock_ctrl.reduction_ratio, clock_ctrl.reduction_active});
      wdiv(OSD_ADDR_CLOCK_DIVIDER, 16'h5801);
      rchk("ratio_frozen", OSD_ADDR_CLOCK_DIVIDER, 32'h0000_3801);
      wdiv(OSD_ADDR_CLOCK_DIVIDER, 16'h3001);
      chk("doze_off", 32'h0, {28'h0, clock_ctrl.reduction_ratio, clock_ctrl.reduction_active});
      wdiv(OSD_ADDR_CLOCK_DIVIDER, 16'h0001);
      wdiv(OSD_ADDR_CLOCK_DIVIDER, 16'h0801);
      rchk("zero_ratio", OSD_ADDR_CLOCK_DIVIDER, 32'h0000_0001);
      for (int k = 0; k < 2; k++) begin
         wdiv(OSD_ADDR_CLOCK_DIVIDER, k == 0 ? 16'hB801 : 16'h3801);
         irq_any <= 1'b1;
         @(posedge core_clk);
         irq_any <= 1'b0;
         settle();
         rchk("irq_recover", OSD_ADDR_CLOCK_DIVIDER, k == 0 ? 32'h0000_B001 : 32'h0000_3801);
      end
   endtask
   task automatic t_low_power_rc_osc();
      power_up_timer_done <= 1'b1;
      settle();
      chk("low_power_rc_osc_idle", 32'h0, {31'h0, low_power_rc_osc_en});
      watchdog_timer_en <= 1'b1;
      settle();
      chk("low_power_rc_osc_watchdog", 32'h1, {31'h0, low_power_rc_osc_en});
      rchk("status_low_power_rc_osc", OSD_ADDR_STATUS, 32'h0000_0004);
      sleep_mode <= 1'b1;
      settle();
      chk("low_power_rc_osc_sleep", 32'h0, {31'h0, low_power_rc_osc_en});
      sleep_mode <= 1'b0;
      watchdog_timer_en <= 1'b0;
   endtask
   // Fuse bit 0 is set here, so the lock bit really freezes the clock settings.
   task automatic t_straps_lock();
      for (int c = 7; c >= 0; c--) begin
         do_reset({c[2:0], OSD_PRI_MEDIUM_CRYSTAL, 1'b1});
         rchk("strap_source", OSD_ADDR_OSC_CONTROL,
            {17'h0, ((c == 4) ? OSD_SRC_FAST_RC : c[2:0]), 1'b0, c[2:0], 8'h00});
      end
      unl_lo(8'h80);
      rchk("lock_set", OSD_ADDR_OSC_CONTROL, 32'h0000_0080);
      wdiv(OSD_ADDR_CLOCK_DIVIDER, 16'h3005);
      rchk("div_locked", OSD_ADDR_CLOCK_DIVIDER, 32'h0000_3001);
      wdiv(OSD_ADDR_PLL_FEEDBACK, 16'h0040);
      rchk("fbd_locked", OSD_ADDR_PLL_FEEDBACK, 32'h0000_0096);
   endtask

   initial begin
      {rst_b, avs_read, avs_write, irq_any, fail_safe_monitor_en, watchdog_timer_en} = 6'h00;
      {power_up_timer_done, sleep_mode, fail_detect, pll_locked, pll_timer_done} = 5'h00;
      avs_address = 4'h0;
      avs_byteenable = 4'h0;
      avs_writedata = 32'h0000_0000;
      config_bits = {OSD_SRC_FAST_RC_DIV_N, OSD_PRI_MEDIUM_CRYSTAL, 1'b0};
      do_reset(config_bits);
      t_reset_values();
      t_unlock_switch();
      t_pll();
      t_fail();
      t_doze();
      t_low_power_rc_osc();
      t_straps_lock();
      wrap_up();
   end
endmodule
